// >>> hdl/mlsa_defines.vh
// Purpose: Constants for the masked load/store alias unit
// Assumes: 8 lanes of 32 bits, 8-entry store buffer, 32-bit addresses
// Notes:   Timing counts are in core clock cycles
`ifndef MLSA_DEFINES_VH
`define MLSA_DEFINES_VH
`define MLSA_LANES        8
`define MLSA_EW           32
`define MLSA_VW           256
`define MLSA_AW           32
`define MLSA_SB_DEPTH     8
`define MLSA_SB_IW        3
`define MLSA_ALIAS_LO     5
`define MLSA_ALIAS_HI     11
`define MLSA_LINE_BITS    6
`define MLSA_ALIAS_PEN    3'h5
`define MLSA_ASSIST_CYC   3'h4
`define MLSA_CNT_W        32
`define MLSA_ST_IDLE      3'h0
`define MLSA_ST_PEN       3'h1
`define MLSA_ST_WCOMMIT   3'h2
`define MLSA_ST_ASSIST    3'h3
`define MLSA_ST_DONE      3'h4
`endif

// >>> hdl/mlsa_lane_mask.v
// Purpose: Masked lane select and fault filter for one vector access
// Assumes: Mask elements are 32 bits wide
// Notes:   Pure combinational
`include "mlsa_defines.vh"
`default_nettype none
module mlsa_lane_mask (
  input  wire [`MLSA_VW-1:0]    mask_vec,
  input  wire [`MLSA_VW-1:0]    mem_data,
  input  wire [`MLSA_LANES-1:0] lane_fault,
  output wire [`MLSA_LANES-1:0] lane_en,
  output wire [`MLSA_VW-1:0]    masked_data,
  output wire                   any_fault,
  output wire                   mask_ones,
  output wire                   mask_zero
);
  genvar g;
  generate
    for (g = 0; g < `MLSA_LANES; g = g + 1) begin : g_lane
      assign lane_en[g] = mask_vec[g*`MLSA_EW+`MLSA_EW-1];
      assign masked_data[g*`MLSA_EW +: `MLSA_EW] =
        lane_en[g] ? mem_data[g*`MLSA_EW +: `MLSA_EW]
                   : {`MLSA_EW{1'b0}};
    end
  endgenerate
  assign any_fault = |(lane_fault & lane_en);
  assign mask_ones = &lane_en;
  assign mask_zero = ~|lane_en;
endmodule // mlsa_lane_mask
`default_nettype wire

// >>> hdl/mlsa_unit.v
// Purpose: Load/store ordering: 4K alias detect, masked vector moves
// Assumes: Store buffer entries allocated in order, committed oldest first
// Notes:   One load in flight; stores enter and commit independently
`include "mlsa_defines.vh"
`default_nettype none
module mlsa_unit (
  input  wire                   core_clk,
  input  wire                   sys_rst,
  // Store issue into store buffer
  input  wire                   st_valid,
  output wire                   st_ready,
  input  wire [`MLSA_AW-1:0]    st_addr,
  input  wire [5:0]             st_size,
  input  wire                   st_masked,
  input  wire                   st_mask_known,
  input  wire [`MLSA_VW-1:0]    st_mask,
  input  wire [`MLSA_VW-1:0]    st_data,
  input  wire [`MLSA_LANES-1:0] st_lane_fault,
  output reg                    st_fault_q,
  // Late mask resolution for the valid store buffer entry at mask_res_idx
  input  wire                   mask_res_valid,
  input  wire [`MLSA_SB_IW-1:0] mask_res_idx,
  input  wire [`MLSA_VW-1:0]    mask_res_val,
  // Disambiguator relief for unresolved stores
  input  wire                   disamb_clear,
  // Commit of the oldest store to the level one data cache
  input  wire                   cache_wr_ready,
  output wire                   cache_wr_valid,
  output wire [`MLSA_AW-1:0]    cache_wr_addr,
  output wire [`MLSA_VW-1:0]    cache_wr_data,
  output wire [`MLSA_LANES-1:0] cache_wr_lane_en,
  // Load issue
  input  wire                   ld_valid,
  output wire                   ld_ready,
  input  wire [`MLSA_AW-1:0]    ld_addr,
  input  wire [5:0]             ld_size,
  input  wire                   ld_vector,
  input  wire                   ld_masked,
  input  wire [`MLSA_VW-1:0]    ld_mask,
  input  wire [`MLSA_VW-1:0]    ld_cache_data,
  input  wire [`MLSA_LANES-1:0] ld_lane_fault,
  // Load answer
  output reg                    ld_done_q,
  output reg  [`MLSA_VW-1:0]    ld_data_q,
  output reg                    ld_fault_q,
  output reg                    ld_alias_q,
  output reg                    ld_fwd_q,
  output reg  [`MLSA_CNT_W-1:0] alias_blocked_load_event_q
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function overlap;
    input [11:0] a;
    input [5:0]  an;
    input [11:0] b;
    input [5:0]  bn;
    begin
      overlap = ({1'b0, a} < {1'b0, b} + {7'h00, bn}) &&
                ({1'b0, b} < {1'b0, a} + {7'h00, an});
    end
  endfunction
  function [`MLSA_LANES-1:0] lanes_of;
    input [`MLSA_VW-1:0] m;
    integer k;
    begin
      lanes_of = {`MLSA_LANES{1'b0}};
      for (k = 0; k < `MLSA_LANES; k = k + 1)
        lanes_of[k] = m[k*`MLSA_EW+`MLSA_EW-1];
    end
  endfunction

  // ---------------------------------------------------------------
  // Store buffer
  // ---------------------------------------------------------------
  reg [`MLSA_AW-1:0]    sb_addr_q  [0:`MLSA_SB_DEPTH-1];
  reg [5:0]             sb_size_q  [0:`MLSA_SB_DEPTH-1];
  reg [`MLSA_VW-1:0]    sb_data_q  [0:`MLSA_SB_DEPTH-1];
  reg [`MLSA_LANES-1:0] sb_lane_q  [0:`MLSA_SB_DEPTH-1];
  reg [`MLSA_SB_DEPTH-1:0] sb_vld_q;
  reg [`MLSA_SB_DEPTH-1:0] sb_msk_q;
  reg [`MLSA_SB_DEPTH-1:0] sb_known_q;
  reg [`MLSA_SB_IW-1:0] sb_wr_q;
  reg [`MLSA_SB_IW-1:0] sb_rd_q;
  reg [`MLSA_SB_IW:0]   sb_cnt_q;

  wire [`MLSA_LANES-1:0] st_en;
  wire                   st_any_fault;
  mlsa_lane_mask u_st_mask (
    .mask_vec    (st_mask),
    .mem_data    (st_data),
    .lane_fault  (st_lane_fault),
    .lane_en     (st_en),
    .masked_data (),
    .any_fault   (st_any_fault),
    .mask_ones   (),
    .mask_zero   ()
  );

  wire st_push = st_valid && st_ready;
  wire sb_empty = (sb_cnt_q == 4'h0);
  // Full exactly when the count reaches the depth
  assign st_ready = !sb_cnt_q[`MLSA_SB_IW];
  // Commit waits until the oldest store knows its mask
  assign cache_wr_valid = !sb_empty && sb_known_q[sb_rd_q];
  assign cache_wr_addr = sb_addr_q[sb_rd_q];
  assign cache_wr_data = sb_data_q[sb_rd_q];
  assign cache_wr_lane_en = sb_lane_q[sb_rd_q];
  wire st_pop = cache_wr_valid && cache_wr_ready;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      sb_vld_q   <= {`MLSA_SB_DEPTH{1'b0}};
      sb_msk_q   <= {`MLSA_SB_DEPTH{1'b0}};
      sb_known_q <= {`MLSA_SB_DEPTH{1'b0}};
      sb_wr_q    <= {`MLSA_SB_IW{1'b0}};
      sb_rd_q    <= {`MLSA_SB_IW{1'b0}};
      sb_cnt_q   <= {(`MLSA_SB_IW+1){1'b0}};
      st_fault_q <= 1'b0;
    end else begin
      st_fault_q <= st_push && st_masked && st_mask_known &&
                    st_any_fault;
      if (mask_res_valid && sb_vld_q[mask_res_idx]) begin
        sb_lane_q[mask_res_idx]  <= lanes_of(mask_res_val);
        sb_known_q[mask_res_idx] <= 1'b1;
      end
      if (st_pop) begin
        sb_vld_q[sb_rd_q] <= 1'b0;
        sb_rd_q <= sb_rd_q + 3'h1;
      end
      if (st_push) begin
        sb_addr_q[sb_wr_q]  <= st_addr;
        sb_size_q[sb_wr_q]  <= st_size;
        sb_data_q[sb_wr_q]  <= st_data;
        sb_lane_q[sb_wr_q]  <= st_masked ? st_en : {`MLSA_LANES{1'b1}};
        sb_vld_q[sb_wr_q]   <= 1'b1;
        sb_msk_q[sb_wr_q]   <= st_masked;
        sb_known_q[sb_wr_q] <= !st_masked || st_mask_known;
        sb_wr_q <= sb_wr_q + 3'h1;
      end
      if (st_push && !st_pop)
        sb_cnt_q <= sb_cnt_q + 4'h1;
      else if (st_pop && !st_push)
        sb_cnt_q <= sb_cnt_q - 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Dependence scan of the issuing load
  // ---------------------------------------------------------------
  reg                   alias_hit;
  reg                   wait_hit;
  reg                   fwd_hit;
  reg [`MLSA_SB_IW-1:0] fwd_idx;
  reg [`MLSA_SB_IW-1:0] e;
  reg                   same;
  reg                   ovl;
  reg [`MLSA_LANES-1:0] ln;
  integer j;
  always @* begin
    alias_hit = 1'b0;
    wait_hit  = 1'b0;
    fwd_hit   = 1'b0;
    fwd_idx   = {`MLSA_SB_IW{1'b0}};
    e = {`MLSA_SB_IW{1'b0}};
    same = 1'b0;
    ovl  = 1'b0;
    ln   = {`MLSA_LANES{1'b0}};
    // Oldest to youngest, so the youngest match wins forwarding
    for (j = 0; j < `MLSA_SB_DEPTH; j = j + 1) begin
      e = sb_rd_q + j[`MLSA_SB_IW-1:0];
      ln = sb_lane_q[e];
      same = (sb_addr_q[e] == ld_addr);
      ovl = overlap(sb_addr_q[e][11:0], sb_size_q[e],
                    ld_addr[11:0], ld_size);
      if (sb_vld_q[e]) begin
        if (sb_msk_q[e] && !sb_known_q[e] && !disamb_clear)
          wait_hit = 1'b1;
        else if (sb_msk_q[e] && (ln == {`MLSA_LANES{1'b0}})) begin
          wait_hit = wait_hit;
        end else if (same && ovl) begin
          if (ln == {`MLSA_LANES{1'b1}}) begin
            fwd_hit = 1'b1;
            fwd_idx = e;
          end else
            wait_hit = 1'b1;
        end else if (!same && ovl &&
                     sb_addr_q[e][`MLSA_ALIAS_HI:`MLSA_ALIAS_LO] ==
                     ld_addr[`MLSA_ALIAS_HI:`MLSA_ALIAS_LO])
          alias_hit = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Masked load lanes
  // ---------------------------------------------------------------
  wire [`MLSA_VW-1:0]    ld_eff_mask = ld_masked ? ld_mask
                                                 : {`MLSA_VW{1'b1}};
  wire [`MLSA_VW-1:0]    ld_src = fwd_hit ? sb_data_q[fwd_idx]
                                          : ld_cache_data;
  wire [`MLSA_VW-1:0]    ld_sel;
  wire                   ld_any_fault;
  wire                   ld_mask_zero;
  mlsa_lane_mask u_ld_mask (
    .mask_vec    (ld_eff_mask),
    .mem_data    (ld_src),
    .lane_fault  (ld_lane_fault),
    .lane_en     (),
    .masked_data (ld_sel),
    .any_fault   (ld_any_fault),
    .mask_ones   (),
    .mask_zero   (ld_mask_zero)
  );
  wire ld_split = ({1'b0, ld_addr[`MLSA_LINE_BITS-1:0]} +
                   {1'b0, ld_size}) > 7'h40;

  // ---------------------------------------------------------------
  // Load sequencer
  // ---------------------------------------------------------------
  reg [2:0] st_q;
  reg [2:0] st_d;
  reg [2:0] cyc_q;
  reg       split_q;
  reg       alias_q;
  reg       fault_q;
  reg       mfault_q;
  reg [`MLSA_VW-1:0] data_q;

  assign ld_ready = (st_q == `MLSA_ST_IDLE) && !wait_hit;
  wire ld_take = ld_valid && ld_ready;
  wire pen_end = (cyc_q == 3'h1);
  wire any_lane_fault = |ld_lane_fault;

  always @* begin
    st_d = st_q;
    case (st_q)
      `MLSA_ST_IDLE: begin
        if (ld_take) begin
          if (alias_hit && ld_split)
            st_d = `MLSA_ST_WCOMMIT;
          else if (alias_hit)
            st_d = `MLSA_ST_PEN;
          else if (ld_masked && any_lane_fault)
            st_d = `MLSA_ST_ASSIST;
          else
            st_d = `MLSA_ST_DONE;
        end
      end
      `MLSA_ST_PEN:
        if (pen_end)
          st_d = mfault_q ? `MLSA_ST_ASSIST : `MLSA_ST_DONE;
      `MLSA_ST_WCOMMIT:
        if (!alias_hit || sb_empty)
          st_d = `MLSA_ST_DONE;
      `MLSA_ST_ASSIST:
        if (pen_end)
          st_d = `MLSA_ST_DONE;
      `MLSA_ST_DONE:
        st_d = `MLSA_ST_IDLE;
      default:
        st_d = `MLSA_ST_IDLE;
    endcase
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      st_q      <= `MLSA_ST_IDLE;
      cyc_q     <= 3'h0;
      split_q   <= 1'b0;
      alias_q   <= 1'b0;
      fault_q   <= 1'b0;
      mfault_q  <= 1'b0;
      data_q    <= {`MLSA_VW{1'b0}};
      ld_done_q <= 1'b0;
      ld_data_q <= {`MLSA_VW{1'b0}};
      ld_fault_q <= 1'b0;
      ld_alias_q <= 1'b0;
      ld_fwd_q   <= 1'b0;
      alias_blocked_load_event_q <= {`MLSA_CNT_W{1'b0}};
    end else begin
      st_q <= st_d;
      ld_done_q <= (st_q == `MLSA_ST_DONE);
      if (ld_take) begin
        split_q  <= ld_split;
        alias_q  <= alias_hit;
        ld_fwd_q <= fwd_hit;
        fault_q  <= ld_any_fault && !ld_mask_zero;
        mfault_q <= ld_masked && any_lane_fault;
        data_q   <= ld_sel;
        if (alias_hit && ld_vector)
          alias_blocked_load_event_q <=
            alias_blocked_load_event_q + 32'h1;
      end
      if (st_q == `MLSA_ST_WCOMMIT && st_d == `MLSA_ST_DONE)
        data_q <= ld_sel;
      if (st_d == `MLSA_ST_PEN && st_q != `MLSA_ST_PEN)
        cyc_q <= `MLSA_ALIAS_PEN;
      else if (st_d == `MLSA_ST_ASSIST && st_q != `MLSA_ST_ASSIST)
        cyc_q <= `MLSA_ASSIST_CYC;
      else if (cyc_q != 3'h0)
        cyc_q <= cyc_q - 3'h1;
      if (st_q == `MLSA_ST_DONE) begin
        ld_data_q  <= data_q;
        ld_fault_q <= fault_q;
        ld_alias_q <= alias_q;
      end
    end
  end
endmodule // mlsa_unit
`default_nettype wire

// >>> verif/mlsa_unit_properties.sv
// Purpose: Port properties of the alias unit
// Assumes: Bound to every mlsa_unit
// Notes:   Store buffer fill is mirrored here
`default_nettype none
module mlsa_unit_properties (
  input wire logic         core_clk,
  input wire logic         sys_rst,
  input wire logic         st_valid,
  input wire logic         st_ready,
  input wire logic         st_masked,
  input wire logic         st_mask_known,
  input wire logic [255:0] st_mask,
  input wire logic [7:0]   st_lane_fault,
  input wire logic         st_fault_q,
  input wire logic         cache_wr_valid,
  input wire logic         cache_wr_ready,
  input wire logic [7:0]   cache_wr_lane_en,
  input wire logic         mask_res_valid,
  input wire logic         disamb_clear,
  input wire logic         ld_valid,
  input wire logic         ld_ready,
  input wire logic         ld_vector,
  input wire logic         ld_masked,
  input wire logic [255:0] ld_mask,
  input wire logic [7:0]   ld_lane_fault,
  input wire logic         ld_done_q,
  input wire logic [255:0] ld_data_q,
  input wire logic         ld_fault_q,
  input wire logic [31:0]  alias_blocked_load_event_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Helper logic
  // ----
  logic [3:0] fill_q;
  logic [7:0] en_q;
  logic [7:0] flt_q;
  logic       msk_q;
  logic [7:0] nz;
  logic       vtake;
  logic       sflt;
  function automatic [7:0] msb(input [255:0] m);
    for (int k = 0; k < 8; k++) msb[k] = m[32*k+31];
  endfunction
  always_comb for (int k = 0; k < 8; k++) nz[k] = |ld_data_q[32*k +: 32];
  assign vtake = ld_valid && ld_ready && ld_vector;
  assign sflt  = st_valid && st_ready && st_masked && st_mask_known
                 && |(st_lane_fault & msb(st_mask));
  always_ff @(posedge core_clk) begin
    if (sys_rst) fill_q <= 4'h0;
    else fill_q <= fill_q + 4'(st_valid && st_ready)
                   - 4'(cache_wr_valid && cache_wr_ready);
    if (ld_valid && ld_ready) begin
      en_q  <= ld_masked ? msb(ld_mask) : 8'hFF;
      flt_q <= ld_lane_fault;
      msk_q <= ld_masked;
    end
  end
  // ----
  // Properties
  // ----
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_take; ld_valid && ld_ready; endsequence
  sequence s_wait; ##[0:600] ld_done_q; endsequence
  load_answer_a: assert property (
    s_take |=> !ld_ready && !ld_done_q ##1 s_wait)
    else $error("load answer early or missing");
  count_step_a: assert property (
    $changed(alias_blocked_load_event_q) |->
    alias_blocked_load_event_q == $past(alias_blocked_load_event_q) + 32'h1)
    else $error("event count jumped");
  count_cause_a: assert property (
    $changed(alias_blocked_load_event_q) |-> $past(vtake))
    else $error("event count without vector load");
  zero_lane_a: assert property (
    ld_done_q |-> (nz & ~en_q) == 8'h00)
    else $error("disabled lane not zero");
  load_fault_a: assert property (
    ld_done_q && msk_q |-> ld_fault_q == |(flt_q & en_q))
    else $error("load fault wrong");
  store_fault_a: assert property (
    st_fault_q == $past(sflt))
    else $error("store fault wrong");
  commit_hold_a: assert property (
    cache_wr_valid && !cache_wr_ready |=>
    cache_wr_valid && $stable(cache_wr_lane_en))
    else $error("commit dropped while stalled");
  buffer_full_a: assert property (st_ready == (fill_q != 4'h8))
    else $error("store ready wrong");
  buffer_empty_a: assert property (fill_q == 4'h0 |-> !cache_wr_valid)
    else $error("commit from empty buffer");
  unknown_hold_a: assert property (
    st_valid && st_ready && st_masked && !st_mask_known && !cache_wr_valid
    && !mask_res_valid |=> !cache_wr_valid && (!ld_ready || disamb_clear))
    else $error("unresolved store not held");
endmodule // mlsa_unit_properties
bind mlsa_unit mlsa_unit_properties chk_u (.core_clk, .sys_rst, .st_valid,
  .st_ready, .st_masked, .st_mask_known, .st_mask, .st_lane_fault,
  .st_fault_q, .cache_wr_valid, .cache_wr_ready, .cache_wr_lane_en,
  .mask_res_valid, .disamb_clear,
  .ld_valid, .ld_ready, .ld_vector, .ld_masked, .ld_mask, .ld_lane_fault,
  .ld_done_q, .ld_data_q, .ld_fault_q, .alias_blocked_load_event_q);
`default_nettype wire

// >>> verif/mlsa_cache_model.sv
// Purpose: Level one data cache commit port model
// Assumes: One line image, address ignored
// Notes:   Ready every other cycle, none while stalled
`default_nettype none
module mlsa_cache_model (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         stall,
  input  wire logic         wr_valid,
  input  wire logic [255:0] wr_data,
  input  wire logic [7:0]   wr_lane_en,
  output var  logic         wr_ready,
  output var  logic [255:0] mem_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Commit port
  // ----
  always @(posedge clk) begin
    wr_ready <= !rst && !stall && !wr_ready;
    if (rst) mem_q <= 256'h0;
    else if (wr_valid && wr_ready)
      for (int k = 0; k < 8; k++)
        if (wr_lane_en[k]) mem_q[32*k +: 32] <= wr_data[32*k +: 32];
  end
endmodule // mlsa_cache_model
`default_nettype wire

// >>> verif/testbench.sv
// Purpose: Self-checking bench for the alias unit
// Assumes: Commit port served by the cache model
// Notes:   Seeded random traffic plus alias and dependence corners
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Signals and instances
  // ----
  logic         core_clk = 1'h0, sys_rst = 1'h1, stall = 1'h0;
  logic         st_valid = 1'h0, st_masked = 1'h0, ld_valid = 1'h0;
  logic         ld_vector = 1'h0, ld_masked = 1'h0;
  logic         st_ready, st_fault_q, cache_wr_valid, cache_wr_ready;
  logic         ld_ready, ld_done_q, ld_fault_q, ld_alias_q, ld_fwd_q;
  logic [5:0]   st_size = 6'h01, ld_size = 6'h01;
  logic [7:0]   st_lane_fault = 8'h00, ld_lane_fault = 8'h00, lf, e;
  logic [7:0]   cache_wr_lane_en;
  logic [31:0]  st_addr = 32'h0, ld_addr = 32'h0, alias_blocked_load_event_q;
  logic [255:0] st_mask = 256'h0, st_data = 256'h0, ld_mask = 256'h0;
  logic [255:0] ld_cache_data = 256'h0, cache_wr_data, ld_data_q, mem_q;
  logic [255:0] mem_x = 256'h0, m, d, c;
  integer       seed = 57, error_cnt = 0, tests_run = 0, lat, i, cnt_x = 0;
  integer       n_st = 0;
  logic         st_mask_known = 1'h1, mask_res_valid = 1'h0;
  logic         disamb_clear = 1'h0;
  logic [2:0]   mask_res_idx = 3'h0;
  logic [31:0]  cache_wr_addr;
  logic [255:0] mask_res_val = 256'h0;
  initial forever #10 core_clk = ~core_clk;
  mlsa_unit dut_u (.core_clk, .sys_rst, .st_valid, .st_ready, .st_addr,
    .st_size, .st_masked, .st_mask_known, .st_mask, .st_data,
    .st_lane_fault, .st_fault_q, .mask_res_valid, .mask_res_idx,
    .mask_res_val, .disamb_clear, .cache_wr_ready,
    .cache_wr_valid, .cache_wr_addr, .cache_wr_data, .cache_wr_lane_en,
    .ld_valid, .ld_ready, .ld_addr, .ld_size, .ld_vector, .ld_masked,
    .ld_mask, .ld_cache_data, .ld_lane_fault, .ld_done_q, .ld_data_q,
    .ld_fault_q, .ld_alias_q, .ld_fwd_q, .alias_blocked_load_event_q);
  mlsa_cache_model far_u (.clk(core_clk), .rst(sys_rst), .stall,
    .wr_valid(cache_wr_valid), .wr_data(cache_wr_data),
    .wr_lane_en(cache_wr_lane_en), .wr_ready(cache_wr_ready), .mem_q);
  // ----
  // Helpers
  // ----
  function automatic [7:0] en(input [255:0] v);
    for (int k = 0; k < 8; k++) en[k] = v[32*k+31];
  endfunction
  function automatic [255:0] pick(input [255:0] a, b, input [7:0] s);
    for (int k = 0; k < 8; k++)
      pick[32*k +: 32] = s[k] ? a[32*k +: 32] : b[32*k +: 32];
  endfunction
  function automatic [255:0] rnd();
    for (int k = 0; k < 8; k++) rnd[32*k +: 32] = $random(seed);
  endfunction
  task automatic chk(input [255:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("errors %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic st(input [31:0] a, input [5:0] sz, input mo,
                    input [255:0] mv, dv, input [7:0] fv);
    logic [7:0] s;
    s = mo ? en(mv) : 8'hFF;
    @(posedge core_clk);
    st_valid <= 1'h1;
    st_addr <= a;
    st_size <= sz;
    st_masked <= mo;
    st_mask <= mv;
    st_data <= dv;
    st_lane_fault <= fv;
    do @(posedge core_clk); while (!st_ready);
    st_valid <= 1'h0;
    n_st++;
    mem_x = pick(dv, mem_x, s);
    #1 chk(st_fault_q, mo && st_mask_known && |(fv & s));
  endtask
  task automatic ld(input [31:0] a, input [5:0] sz, input v, mo,
                    input [255:0] mv, cv, input [7:0] fv);
    @(posedge core_clk);
    ld_valid <= 1'h1;
    ld_addr <= a;
    ld_size <= sz;
    ld_vector <= v;
    ld_masked <= mo;
    ld_mask <= mv;
    ld_cache_data <= cv;
    ld_lane_fault <= fv;
    do @(posedge core_clk); while (!ld_ready);
    ld_valid <= 1'h0;
    #1;
    // Edges from take until ld_done_q has risen
    for (lat = 0; lat < 600 && ld_done_q !== 1'h1; lat++)
      @(posedge core_clk) #1;
  endtask
  task automatic drain;
    stall <= 1'h0;
    for (i = 0; i < 100 && cache_wr_valid !== 1'h0; i++) @(posedge core_clk);
    @(posedge core_clk);
    chk(mem_q, mem_x);
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    test_done;
  end
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'h0;
    @(posedge core_clk) #1;
    chk(alias_blocked_load_event_q, 0);
    for (int r = 0; r < 3; r++) begin
      stall <= 1'h1;
      for (int j = 0; j < 8; j++) begin
        m = rnd();
        lf = $random(seed);
        st($random(seed), 6'h01 + 6'(j * 4), j[0], m, rnd(), lf);
      end
      chk(st_ready, 0);
      drain;
    end
    for (int n = 0; n < 40; n++) begin
      m = (n % 5 == 1) ? 256'h0 : rnd();
      c = rnd();
      lf = n[0] ? 8'($random(seed)) : 8'h00;
      ld($random(seed), 6'h01 + 6'(n & 31), n[1], n[0], m, c, lf);
      e = n[0] ? en(m) : 8'hFF;
      chk(ld_data_q, pick(c, 256'h0, e));
      chk(ld_fault_q, n[0] && |(lf & e));
      chk(lat, lf != 8'h00 ? 5 : 1);
    end
    // Alias corners; the last spans two lines and waits for commit
    for (int k = 0; k < 4; k++) begin
      c = rnd();
      stall <= 1'h1;
      st(k == 3 ? 32'h0040_1030 : 32'h0040_1020, k == 1 ? 6'h04 : 6'h20,
         1'h0, 256'h0, rnd(), 8'h00);
      fork
        ld(k[0] ? 32'h0040_0030 : 32'h0040_0020, k == 1 ? 6'h04 : 6'h20,
           k != 2, 1'h0, 256'h0, c, 8'h00);
        if (k == 3) begin
          repeat (6) @(posedge core_clk);
          stall <= 1'h0;
        end
      join
      cnt_x += (k == 0 || k == 3);
      chk(ld_alias_q, k != 1);
      if (k == 3) chk(lat, 8);
      else chk(lat, k == 1 ? 1 : 6);
      if (k != 3) chk(cache_wr_addr, 32'h0040_1020);
      chk(ld_data_q, c);
      chk(alias_blocked_load_event_q, cnt_x);
      drain;
    end
    for (int k = 0; k < 3; k++) begin
      m = k == 0 ? {8{32'h8000_0000}} : k == 1 ? 256'h0 : {4{64'h8000_0000}};
      d = rnd();
      c = rnd();
      stall <= 1'h1;
      st(32'h0000_6000, 6'h20, 1'h1, m, d, 8'h00);
      if (k == 2) begin
        @(posedge core_clk);
        ld_addr <= 32'h0000_6000;
        ld_size <= 6'h20;
        repeat (3) @(posedge core_clk) #1;
        chk(ld_ready, 0);
        stall <= 1'h0;
      end
      ld(32'h0000_6000, 6'h20, 1'h0, 1'h0, 256'h0, c, 8'h00);
      chk(ld_fwd_q, k == 0);
      chk(ld_data_q, k == 0 ? d : c);
      chk(lat, 1);
      drain;
    end
    // Late mask: commit held until it arrives, younger loads until disamb_clear
    st_mask_known <= 1'h0;
    m = {4{64'h8000_0000}};
    st(32'h0000_7000, 6'h20, 1'h1, m, rnd(), 8'h00);
    repeat (3) @(posedge core_clk) #1;
    chk(cache_wr_valid, 0);
    chk(ld_ready, 0);
    @(posedge core_clk);
    disamb_clear <= 1'h1;
    @(posedge core_clk) #1;
    chk(ld_ready, 1);
    @(posedge core_clk);
    disamb_clear <= 1'h0;
    mask_res_valid <= 1'h1;
    mask_res_idx <= 3'(n_st - 1);
    mask_res_val <= m;
    @(posedge core_clk);
    mask_res_valid <= 1'h0;
    st_mask_known <= 1'h1;
    #1 drain;
    test_done;
  end
endmodule // testbench
`default_nettype wire
